// ===== verilog/stla_top.sv
/*
 Sequential trigger unit with Avalon-MM register slave, three match
 stages, monitor capture and a level interrupt.
 Assumes trigger and monitor channels are driven on mclk_i and that
 the debug host reaches the bus through its own bridge.
*/
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`default_nettype none
`timescale 1ns/1ps
module stla_top #(
   parameter int TRIG_W = 40,
   parameter int MON_W = 4087
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire stla_pkg::stla_req_s avs_req_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [TRIG_W-1:0] trig_i,
   input wire logic [MON_W-1:0] mon_i,
   output logic irq_o,
   output logic trig_done_o,
   output logic armed_o
);
   // ------------------------------------------------------------------
   // Sizes and elaboration checks
   // ------------------------------------------------------------------
   localparam int PAT_WORDS = (TRIG_W + stla_pkg::CH_PER_WORD - 1) / stla_pkg::CH_PER_WORD;
   localparam int CAP_WORDS = (MON_W + 31) / 32;

   if (TRIG_W < 1 || TRIG_W > stla_pkg::TRIG_W_MAX) begin : g_bad_trig
      $error("Trigger width out of range");
   end
   if (MON_W < 1 || MON_W > stla_pkg::MON_W_MAX) begin : g_bad_mon
      $error("Monitor width out of range");
   end

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      stla_pkg::stla_state_e fsm;          // Trigger sequence
      logic [1:0] stages;                  // Selected stage count
      logic [2:0][3*TRIG_W-1:0] pat;       // Stage patterns
      logic [TRIG_W-1:0] prev;             // Last trigger sample
      logic [CAP_WORDS*32-1:0] cap;        // Captured record
      logic [1:0] irq_stat;                // Sticky events
      logic [1:0] irq_en;                  // Event enables
      logic irq;                           // Interrupt level
      logic waitreq;                       // Bus stall
      logic [31:0] rdata;                  // Read answer
      logic done;                          // Trigger complete, registered for the pin
      logic armed;                         // Waiting in a stage, registered for the pin
   } stla_reg_s;

   stla_reg_s r;
   stla_reg_s next_r;
   logic [2:0] m;                          // Stage matches this cycle

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Zero count is read as one so the unit can never hang on no stages
   function automatic logic [1:0] eff_stages(input logic [1:0] s);
      return (s == 2'h0) ? 2'h1 : s;
   endfunction

   function automatic logic [12:0] pat_addr(input int s, input int w);
      return 13'(stla_pkg::PAT_BASE + s * stla_pkg::PAT_STRIDE + w * 4);
   endfunction

   // ------------------------------------------------------------------
   // Stage matchers
   // ------------------------------------------------------------------
   for (genvar s = 0; s < 3; s++) begin : g_stage
      stla_match #(.TRIG_W(TRIG_W)) u_match (
         .cur_i(trig_i),
         .prev_i(r.prev),
         .pat_i(r.pat[s]),
         .match_o(m[s])
      );
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic take;
      logic commit;
      logic fire;
      logic step;
      logic [1:0] clr;
      logic [12:0] a;
      logic [31:0] rd;
      take = 1'b0;
      commit = 1'b0;
      fire = 1'b0;
      step = 1'b0;
      clr = 2'h0;
      a = avs_req_i.address;
      rd = 32'h0000_0000;
      next_r = r;
      next_r.prev = trig_i;

      // Sequence; each stage is tested from the cycle after the last
      case (r.fsm)
         stla_pkg::ST_WAIT1: begin
            if (m[0]) begin
               if (eff_stages(r.stages) == 2'h1) fire = 1'b1;
               else begin
                  next_r.fsm = stla_pkg::ST_WAIT2;
                  step = 1'b1;
               end
            end
         end
         stla_pkg::ST_WAIT2: begin
            if (m[1]) begin
               if (eff_stages(r.stages) == 2'h2) fire = 1'b1;
               else begin
                  next_r.fsm = stla_pkg::ST_WAIT3;
                  step = 1'b1;
               end
            end
         end
         stla_pkg::ST_WAIT3: begin
            if (m[2]) fire = 1'b1;
         end
         stla_pkg::ST_IDLE, stla_pkg::ST_DONE: begin
            next_r.fsm = r.fsm;
         end
         default: begin
            next_r.fsm = stla_pkg::ST_IDLE;
         end
      endcase
      // One record per arm: the sample of the final matching cycle
      if (fire) begin
         next_r.fsm = stla_pkg::ST_DONE;
         next_r.cap = '0;
         next_r.cap[MON_W-1:0] = mon_i;
      end

      // Bus: first sight stalls one cycle, the next edge completes
      take = (avs_req_i.read || avs_req_i.write) && r.waitreq;
      commit = (avs_req_i.read || avs_req_i.write) && !r.waitreq;
      next_r.waitreq = !take;

      // Read decode; unmapped words answer zero
      case (a)
         stla_pkg::CTRL_OFS: rd[stla_pkg::CTRL_STG_LSB +: 2] = r.stages;
         stla_pkg::STAT_OFS: begin
            rd[stla_pkg::STAT_ARMED_BIT] = armed_o;
            rd[stla_pkg::STAT_DONE_BIT] = trig_done_o;
            rd[stla_pkg::STAT_STG_LSB +: 2] = r.fsm[3] ? 2'h3 : (r.fsm[2] ? 2'h2 : 2'h1);
         end
         stla_pkg::IRQ_STAT_OFS: rd[1:0] = r.irq_stat;
         stla_pkg::IRQ_EN_OFS: rd[1:0] = r.irq_en;
         stla_pkg::PARAM_OFS: rd = {16'(MON_W), 16'(TRIG_W)};
         default: begin
            for (int s = 0; s < 3; s++) begin
               for (int c = 0; c < TRIG_W; c++) begin
                  if (a == pat_addr(s, c / stla_pkg::CH_PER_WORD)) begin
                     rd[(c % stla_pkg::CH_PER_WORD)*3 +: 3] = r.pat[s][c*3 +: 3];
                  end
               end
            end
            for (int w = 0; w < CAP_WORDS; w++) begin
               if (a == 13'(stla_pkg::CAP_BASE + w * 4)) rd = r.cap[w*32 +: 32];
            end
         end
      endcase
      if (take && avs_req_i.read) next_r.rdata = rd;

      // Writes take effect on the completing edge only
      if (commit && avs_req_i.write) begin
         case (a)
            stla_pkg::CTRL_OFS: begin
               next_r.stages = avs_req_i.writedata[stla_pkg::CTRL_STG_LSB +: 2];
               if (avs_req_i.writedata[stla_pkg::CTRL_ARM_BIT]) begin
                  next_r.fsm = stla_pkg::ST_WAIT1;
               end
               if (avs_req_i.writedata[stla_pkg::CTRL_SRST_BIT]) begin
                  next_r.fsm = stla_pkg::ST_IDLE;
                  next_r.cap = '0;
               end
            end
            stla_pkg::IRQ_CLR_OFS: clr = avs_req_i.writedata[1:0];
            stla_pkg::IRQ_EN_OFS: next_r.irq_en = avs_req_i.writedata[1:0];
            default: begin
               for (int s = 0; s < 3; s++) begin
                  for (int c = 0; c < TRIG_W; c++) begin
                     if (a == pat_addr(s, c / stla_pkg::CH_PER_WORD)) begin
                        next_r.pat[s][c*3 +: 3] =
                           avs_req_i.writedata[(c % stla_pkg::CH_PER_WORD)*3 +: 3];
                     end
                  end
               end
            end
         endcase
      end

      // Sticky events: a set in the clearing cycle wins
      next_r.irq_stat = (r.irq_stat & ~clr) | {step, fire};
      next_r.irq = |(next_r.irq_stat & next_r.irq_en);
      // Status pins follow the next state so they stay in step with it
      next_r.done = (next_r.fsm == stla_pkg::ST_DONE);
      next_r.armed = |next_r.fsm[3:1];
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   // Patterns reset to don't care everywhere
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
         r.fsm <= stla_pkg::ST_IDLE;
         r.stages <= stla_pkg::STG_RST;
         r.irq_en <= stla_pkg::IRQ_EN_RST;
         r.waitreq <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign avs_readdata_o = r.rdata;
   assign avs_waitrequest_o = r.waitreq;
   assign irq_o = r.irq;
   assign trig_done_o = r.done;
   assign armed_o = r.armed;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   logic arm_wr;
   assign arm_wr = avs_req_i.write && !r.waitreq && avs_req_i.address == stla_pkg::CTRL_OFS;

   a_prev_sample: assert property (
      ##1 r.prev == $past(trig_i)) else $error("Previous sample not kept");
   a_arm_starts: assert property (
      arm_wr && avs_req_i.writedata[0] && !avs_req_i.writedata[1]
      |=> r.fsm == stla_pkg::ST_WAIT1) else $error("Arm did not start stage one");
   a_one_stage: assert property (
      r.fsm == stla_pkg::ST_WAIT1 && m[0] && eff_stages(r.stages) == 2'h1 && !arm_wr
      |=> trig_done_o) else $error("Single stage did not fire");
   a_two_order: assert property (
      $rose(r.fsm == stla_pkg::ST_WAIT2) |-> $past(r.fsm == stla_pkg::ST_WAIT1) && $past(m[0]))
      else $error("Stage two entered out of order");
   a_three_order: assert property (
      $rose(trig_done_o) && eff_stages(r.stages) == 2'h3
      |-> $past(r.fsm == stla_pkg::ST_WAIT3) && $past(m[2])) else $error("Stage three skipped");
   a_done_hold: assert property (
      trig_done_o && !arm_wr |=> trig_done_o && $stable(r.cap)) else $error("Record lost");
   a_bus_answer: assert property (
      (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o ##1
      avs_waitrequest_o) else $error("Bus answer not one cycle");
   a_irq_level: assert property (
      irq_o == |(r.irq_stat & r.irq_en)) else $error("Interrupt level wrong");
   a_fire_sticky: assert property (
      $rose(trig_done_o) |-> r.irq_stat[stla_pkg::IRQ_DONE_BIT])
      else $error("Fire event not recorded");

   c_fire_one: cover property ($rose(trig_done_o) && eff_stages(r.stages) == 2'h1);
   c_fire_two: cover property ($rose(trig_done_o) && r.stages == 2'h2);
   c_fire_three: cover property ($rose(trig_done_o) && r.stages == 2'h3);
   c_irq: cover property ($rose(irq_o));
endmodule // stla_top
`default_nettype wire

// ===== verilog/stla_pkg.sv
/*
 Package of the sequential trigger unit: register map, field positions,
 reset values, match condition codes, bus request carrier and FSM states.
 Assumes a 32-bit Avalon-MM slave with byte addresses and word access.
*/
`default_nettype none
package stla_pkg;
   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam logic [12:0] CTRL_OFS = 13'h0000;     // Arm, soft reset, stage count
   localparam logic [12:0] STAT_OFS = 13'h0004;     // Armed, complete, stage
   localparam logic [12:0] IRQ_STAT_OFS = 13'h0008; // Sticky events, read only
   localparam logic [12:0] IRQ_CLR_OFS = 13'h000C;  // Write one to clear
   localparam logic [12:0] IRQ_EN_OFS = 13'h0010;   // Interrupt enables
   localparam logic [12:0] PARAM_OFS = 13'h0014;    // Built-in channel widths
   localparam logic [12:0] PAT_BASE = 13'h0100;     // Stage patterns
   localparam logic [12:0] PAT_STRIDE = 13'h0020;   // Bytes between stages
   localparam logic [12:0] CAP_BASE = 13'h1000;     // Captured monitor words
   // ------------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------------
   localparam int CTRL_ARM_BIT = 0;
   localparam int CTRL_SRST_BIT = 1;
   localparam int CTRL_STG_LSB = 2;
   localparam int STAT_ARMED_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_STG_LSB = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_STEP_BIT = 1;
   localparam int CH_PER_WORD = 10;                 // Three bits per channel
   localparam int COND_W = 3;
   localparam logic [1:0] STG_RST = 2'h1;
   localparam logic [1:0] IRQ_EN_RST = 2'h0;
   localparam int TRIG_W_MAX = 40;
   localparam int MON_W_MAX = 4087;
   // ------------------------------------------------------------------
   // Per-channel match conditions; unused codes act as don't care
   // ------------------------------------------------------------------
   localparam logic [2:0] COND_X = 3'h0;
   localparam logic [2:0] COND_RISE = 3'h1;
   localparam logic [2:0] COND_FALL = 3'h2;
   localparam logic [2:0] COND_LOW = 3'h3;
   localparam logic [2:0] COND_HIGH = 3'h4;
   // ------------------------------------------------------------------
   // Carriers and states
   // ------------------------------------------------------------------
   typedef struct packed {
      logic read;
      logic write;
      logic [12:0] address;
      logic [31:0] writedata;
   } stla_req_s;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_WAIT1 = 5'h02,
      ST_WAIT2 = 5'h04,
      ST_WAIT3 = 5'h08,
      ST_DONE = 5'h10
   } stla_state_e;
endpackage
`default_nettype wire

// ===== verilog/stla_match.sv
/*
 One trigger stage: compares every channel against its condition.
 Assumes the current and previous samples come from the same clock.
*/
`default_nettype none
`timescale 1ns/1ps
module stla_match #(
   parameter int TRIG_W = 40
) (
   input wire logic [TRIG_W-1:0] cur_i,
   input wire logic [TRIG_W-1:0] prev_i,
   input wire logic [3*TRIG_W-1:0] pat_i,
   output logic match_o
);
   // ------------------------------------------------------------------
   // Channel compare
   // ------------------------------------------------------------------
   // Stage matches only when every channel is satisfied
   always_comb begin
      match_o = 1'b1;
      for (int c = 0; c < TRIG_W; c++) begin
         case (pat_i[c*3 +: 3])
            stla_pkg::COND_RISE: begin
               if (!(!prev_i[c] && cur_i[c])) match_o = 1'b0;
            end
            stla_pkg::COND_FALL: begin
               if (!(prev_i[c] && !cur_i[c])) match_o = 1'b0;
            end
            stla_pkg::COND_LOW: begin
               if (cur_i[c]) match_o = 1'b0;
            end
            stla_pkg::COND_HIGH: begin
               if (!cur_i[c]) match_o = 1'b0;
            end
            default: begin
               match_o = match_o; // Don't care
            end
         endcase
      end
   end
endmodule // stla_match
`default_nettype wire

// ===== test/stla_host_model.sv
/*
 Debug host model: drives the register bus as an Avalon-MM master.
 Assumes one clock shared with the trigger unit and a bench that calls
 its tasks right after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module stla_host_model #(
   parameter int REC_LIMIT = 128, // Record ceiling
   parameter int MODE_SINGLE = 1 // Single arm unless told otherwise
) (
   input wire logic mclk_i,
   input wire logic [31:0] avs_readdata_i,
   input wire logic avs_waitrequest_i,
   output var stla_pkg::stla_req_s req_o
);
   // -------------------------------------------------
   // Bus cycle
   // -------------------------------------------------
   initial req_o = '0;

   // Holds the request until waitrequest is sampled low; no cycle count assumed
   task automatic xfer(input logic rd, input logic [12:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge mclk_i);
      req_o <= '{read: rd, write: !rd, address: a, writedata: d};
      do @(posedge mclk_i); while (avs_waitrequest_i !== 1'b0);
      q = avs_readdata_i;
      req_o <= '0;
   endtask

   // -------------------------------------------------
   // Trigger modes
   // -------------------------------------------------
   // Arms once with the conditions already in place
   task automatic arm(input logic [1:0] stages);
      logic [31:0] q;
      xfer(1'b0, stla_pkg::CTRL_OFS, {28'h0, stages, 2'h1}, q);
   endtask

   // Immediate mode: every stage word cleared to don't care first
   task automatic arm_now();
      logic [31:0] q;
      for (int s = 0; s < 3; s++) begin
         for (int w = 0; w < 4; w++) begin
            xfer(1'b0, 13'(stla_pkg::PAT_BASE + 32'h20 * s + 4 * w), 32'h0, q);
         end
      end
      arm(2'h1);
   endtask

   // Default arming: single unless the host is built for immediate
   task automatic arm_default(input logic [1:0] stages);
      if (MODE_SINGLE != 0) arm(stages);
      else arm_now();
   endtask

   // Repetitive mode: keeps conditions, re-arms after each record
   task automatic repeat_run(input int n, output int got);
      logic [31:0] q;
      got = 0;
      for (int r = 0; r < n && r < REC_LIMIT; r++) begin
         arm(2'h1);
         do xfer(1'b1, stla_pkg::STAT_OFS, 32'h0, q); while (q[1] !== 1'b1);
         got++;
      end
   endtask
endmodule // stla_host_model
`default_nettype wire

// ===== test/stla_top_bench.sv
/*
 Self-checking bench of the trigger unit: register map, match codes,
 stage order, capture hold, interrupt and repetitive re-arm.
 Assumes the host model file and the design package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH at %0t got %h expected %h", $time, (g), (e)); end end
module stla_top_bench;
   localparam int TW = 12; // Small trigger width keeps stimulus short
   localparam int MW = 40; // Spans two capture words
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [TW-1:0] trig = '0;
   logic [MW-1:0] mon = '0;
   logic [MW-1:0] snap; // Monitor value expected in the record
   logic [31:0] q;
   logic [31:0] rdata;
   logic wreq, irq, done, armed;
   stla_pkg::stla_req_s req;
   int errors = 0;
   int total_checks = 0;
   int got;
   logic [2:0] cnd [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5}; // Every match code, one spare
   logic idl [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0}; // Rest level; must not match except under the don't care codes 0 and 5

   stla_top #(.TRIG_W(TW), .MON_W(MW)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
      .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .trig_i(trig), .mon_i(mon), .irq_o(irq), .trig_done_o(done), .armed_o(armed));
   stla_host_model host (.mclk_i(mclk_i), .avs_readdata_i(rdata),
      .avs_waitrequest_i(wreq), .req_o(req));

   // -------------------------------------------------
   // Helpers
   // -------------------------------------------------
   initial forever #2 mclk_i = ~mclk_i;

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      host.xfer(1'b0, a, d, q);
   endtask
   task automatic rdc(input logic [12:0] a, input logic [31:0] e);
      host.xfer(1'b1, a, 32'h0, q);
      `CHK(q, e)
   endtask
   // Trigger step, then status readback
   task automatic step(input logic [TW-1:0] v, input logic [31:0] e);
      trig <= v;
      tick(3);
      rdc(stla_pkg::STAT_OFS, e);
   endtask
   task automatic pat(input int s, input logic [31:0] d);
      wr(13'(stla_pkg::PAT_BASE + 32'h20 * s), d);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Watchdog: whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge mclk_i);
      errors++;
      conclude();
   end

   // -------------------------------------------------
   // Tests
   // -------------------------------------------------
   initial begin
      tick(2);
      rst_i <= 1'b0;
      tick(1);
      // Reset values, read-only and unmapped places
      rdc(stla_pkg::CTRL_OFS, 32'h4);
      rdc(stla_pkg::PARAM_OFS, {16'(MW), 16'(TW)});
      rdc(13'h0040, 32'h0);
      wr(stla_pkg::STAT_OFS, 32'hFFFFFFFF);
      rdc(stla_pkg::STAT_OFS, 32'h4);
      $display("test map done");
      // Each code on channel 0: no fire at rest except the don't care codes 0 and 5, fire on the change
      for (int i = 0; i < 6; i++) begin
         trig <= TW'(idl[i]);
         mon <= {8'(i), 32'hC0DE0000 | 32'(i)};
         pat(0, {29'h0, cnd[i]});
         host.arm(2'h1);
         tick(3);
         snap = mon;
         `CHK(done, cnd[i] == 3'h0 || cnd[i] > 3'h4)
         trig <= TW'(!idl[i]);
         tick(3);
         `CHK(done, 1'b1)
         `CHK(armed, 1'b0)
         mon <= ~mon;
         tick(2);
         rdc(stla_pkg::CAP_BASE, snap[31:0]);
         rdc(stla_pkg::CAP_BASE + 13'h4, {24'h0, snap[39:32]});
      end
      $display("test codes done");
      // Stage patterns: ch1, ch2, ch3 high in stages one to three
      pat(0, 32'(stla_pkg::COND_HIGH) << 3);
      pat(1, 32'(stla_pkg::COND_HIGH) << 6);
      pat(2, 32'(stla_pkg::COND_HIGH) << 9);
      trig <= '0;
      host.arm(2'h3);
      step(12'h00C, 32'h5);
      step(12'h002, 32'h9);
      step(12'h008, 32'h9);
      step(12'h004, 32'hD);
      step(12'h008, 32'h6);
      trig <= '0;
      host.arm(2'h2);
      step(12'h00C, 32'h5);
      step(12'h002, 32'h9);
      step(12'h004, 32'h6);
      trig <= '0;
      host.arm_default(2'h1);
      step(12'h002, 32'h6);
      $display("test stages done");
      // Sticky events: fired and stage advanced, masked then enabled
      rdc(stla_pkg::IRQ_STAT_OFS, 32'h3);
      `CHK(irq, 1'b0)
      wr(stla_pkg::IRQ_EN_OFS, 32'h1);
      tick(2);
      `CHK(irq, 1'b1)
      wr(stla_pkg::IRQ_CLR_OFS, 32'h1);
      tick(2);
      `CHK(irq, 1'b0)
      rdc(stla_pkg::IRQ_STAT_OFS, 32'h2);
      wr(stla_pkg::IRQ_EN_OFS, 32'h3);
      tick(2);
      `CHK(irq, 1'b1)
      wr(stla_pkg::IRQ_CLR_OFS, 32'h3);
      tick(2);
      `CHK(irq, 1'b0)
      $display("test irq done");
      // Immediate arming repeated, then soft reset drops the record
      host.arm_now();
      tick(2);
      `CHK(done, 1'b1)
      host.repeat_run(3, got);
      `CHK(32'(got), 32'h3)
      wr(stla_pkg::CTRL_OFS, 32'h2);
      rdc(stla_pkg::STAT_OFS, 32'h4);
      rdc(stla_pkg::CAP_BASE, 32'h0);
      $display("test repeat done");
      conclude();
   end
endmodule // stla_top_bench
`default_nettype wire
